// ---- hw/sebt_top.sv ----
// Two-wire bus target of a byte-wide serial EEPROM with its storage array.
// Assumes SCL, SDA and straps arrive asynchronously and are oversampled by ref_clk,
// and that the SDA wire is pulled up outside and resolved from sda_oe.
`timescale 1ns/1ps
`include "sebt_defs.svh"

module sebt_top
  import sebt_pkg::*;
#(
  parameter int PROG_CYCLES = `SEBT_PROG_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic chip_select_strap_low,
  input wire logic chip_select_strap_high,
  input wire logic write_protect,
  output logic standby,
  output logic prog_busy
);

  sebt_pins_t pins_meta_reg;
  sebt_pins_t pins_reg;
  sebt_pins_t pins_prev_reg;
  sebt_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic ack_clk_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic sda_drive_reg;
  logic send_next_reg;
  logic page_select_bit_reg;
  logic [7:0] addr_hi_reg;
  logic [`SEBT_ADDR_W-1:0] addr_ptr_reg;
  logic wr_pending_reg;
  logic prog_start_reg;
  logic scan_active_reg;
  logic [`SEBT_PAGE_W-1:0] scan_idx_reg;
  logic [`SEBT_ADDR_W-`SEBT_PAGE_W-1:0] commit_row_reg;
  logic standby_reg;
  logic [7:0] page_buf [0:`SEBT_PAGE_BYTES-1];
  logic [`SEBT_PAGE_BYTES-1:0] buf_valid;
  logic [7:0] mem [0:`SEBT_MEM_BYTES-1];
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_end;
  logic ack_end;
  logic dev_match;
  logic tmr_busy;
  logic busy;
  logic buf_clear;
  logic buf_store;
  sebt_pins_t pins_raw;

  assign pins_raw = '{wp: write_protect, sel_hi: chip_select_strap_high,
                      sel_lo: chip_select_strap_low, scl: scl_in, sda: sda_in};

  // Two-stage synchroniser, then one stage of history for edge finding
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pins_meta_reg <= '{wp: 1'b0, sel_hi: 1'b0, sel_lo: 1'b0, scl: 1'b1, sda: 1'b1};
      pins_reg <= '{wp: 1'b0, sel_hi: 1'b0, sel_lo: 1'b0, scl: 1'b1, sda: 1'b1};
      pins_prev_reg <= '{wp: 1'b0, sel_hi: 1'b0, sel_lo: 1'b0, scl: 1'b1, sda: 1'b1};
    end
    else
    begin
      pins_meta_reg <= pins_raw;
      pins_reg <= pins_meta_reg;
      pins_prev_reg <= pins_reg;
    end
  end

  // Bus events; SDA moving while SCL stays high frames a command
  assign scl_rise = pins_reg.scl && !pins_prev_reg.scl;
  assign scl_fall = !pins_reg.scl && pins_prev_reg.scl;
  assign start_seen = pins_reg.scl && pins_prev_reg.scl
                      && pins_prev_reg.sda && !pins_reg.sda;
  assign stop_seen = pins_reg.scl && pins_prev_reg.scl
                     && !pins_prev_reg.sda && pins_reg.sda;
  assign byte_end = scl_fall && (bit_cnt_reg == 4'h8) && !ack_clk_reg;
  assign ack_end = scl_fall && (bit_cnt_reg == 4'h8) && ack_clk_reg;

  // Address word: type nibble, two strap bits, page bit, direction
  assign dev_match = (shift_reg[7:4] == `SEBT_DEV_TYPE)
                     && (shift_reg[`SEBT_SEL_HI_BIT] == pins_reg.sel_hi)
                     && (shift_reg[`SEBT_SEL_LO_BIT] == pins_reg.sel_lo);

  assign busy = tmr_busy || scan_active_reg;
  assign buf_clear = byte_end && (state_reg == SEBT_ADL);
  assign buf_store = byte_end && (state_reg == SEBT_WDATA);

  // Bit counter and ninth-clock marker
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      bit_cnt_reg <= 4'h0;
      ack_clk_reg <= 1'b0;
    end
    else if (start_seen || stop_seen)
    begin
      bit_cnt_reg <= 4'h0;
      ack_clk_reg <= 1'b0;
    end
    else if (scl_rise && bit_cnt_reg != 4'h8)
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    else if (scl_rise)
      ack_clk_reg <= 1'b1;
    else if (ack_end)
    begin
      bit_cnt_reg <= 4'h0;
      ack_clk_reg <= 1'b0;
    end
  end

  // Incoming bits are taken on the SCL rise only
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      shift_reg <= 8'h00;
    else if (scl_rise && bit_cnt_reg != 4'h8)
      shift_reg <= {shift_reg[6:0], pins_reg.sda};
  end

  // Command sequencer; STOP or a refused address falls back to standby
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      state_reg <= SEBT_IDLE;
    else if (start_seen)
      state_reg <= SEBT_DEV;
    else if (stop_seen)
      state_reg <= SEBT_IDLE;
    else if (byte_end)
    begin
      case (state_reg)
        SEBT_DEV:
        begin
          if (!dev_match || busy)
            state_reg <= SEBT_IDLE;
          else if (shift_reg[`SEBT_RW_BIT])
            state_reg <= SEBT_RDATA;
          else
            state_reg <= SEBT_ADH;
        end
        SEBT_ADH: state_reg <= SEBT_ADL;
        SEBT_ADL: state_reg <= SEBT_WDATA;
        default: state_reg <= state_reg;
      endcase
    end
    else if (ack_end && state_reg == SEBT_RDATA && !send_next_reg)
      state_reg <= SEBT_WAIT;
  end

  // Address capture and auto-increment
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      page_select_bit_reg <= 1'b0;
      addr_hi_reg <= 8'h00;
      addr_ptr_reg <= '0;
    end
    else if (byte_end && state_reg == SEBT_DEV && dev_match && !busy)
      page_select_bit_reg <= shift_reg[`SEBT_PAGE_BIT];
    else if (byte_end && state_reg == SEBT_ADH)
      addr_hi_reg <= shift_reg;
    else if (buf_clear)
      addr_ptr_reg <= {page_select_bit_reg, addr_hi_reg, shift_reg};
    else if (buf_store)
      addr_ptr_reg[7:0] <= addr_ptr_reg[7:0] + 8'h01;
    else if (ack_end && state_reg == SEBT_RDATA && send_next_reg)
      addr_ptr_reg <= addr_ptr_reg + 17'h00001; // Reads roll over the whole array
  end

  // Page buffer data; only acknowledged bytes land here
  always_ff @(posedge ref_clk)
  begin
    if (buf_store)
      page_buf[addr_ptr_reg[7:0]] <= shift_reg;
  end

  // Per-entry valid bits so a partial page programs only what was sent
  genvar gi;
  generate
    for (gi = 0; gi < `SEBT_PAGE_BYTES; gi++)
    begin : g_valid
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
          buf_valid[gi] <= 1'b0;
        else if (buf_store && addr_ptr_reg[7:0] == 8'(gi))
          buf_valid[gi] <= 1'b1;
        else if (buf_clear)
          buf_valid[gi] <= 1'b0;
      end
    end
  endgenerate

  // SDA driver: pull low for ack or a zero data bit, else release
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || start_seen || stop_seen)
      sda_drive_reg <= 1'b0;
    else if (byte_end)
    begin
      case (state_reg)
        SEBT_DEV: sda_drive_reg <= dev_match && !busy;
        SEBT_ADH, SEBT_ADL, SEBT_WDATA: sda_drive_reg <= 1'b1;
        default: sda_drive_reg <= 1'b0; // Release so the host can answer
      endcase
    end
    else if (ack_end && state_reg == SEBT_RDATA && send_next_reg)
      sda_drive_reg <= !mem[addr_ptr_reg][7];
    else if (ack_end)
      sda_drive_reg <= 1'b0;
    else if (scl_fall && state_reg == SEBT_RDATA && bit_cnt_reg != 4'h8
             && bit_cnt_reg != 4'h0)
      sda_drive_reg <= !tx_reg[6];
  end

  // Read shifter and the host's request for another byte
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      tx_reg <= 8'h00;
      send_next_reg <= 1'b0;
    end
    else if (byte_end && state_reg == SEBT_DEV)
      send_next_reg <= 1'b1;
    else if (scl_rise && bit_cnt_reg == 4'h8 && state_reg == SEBT_RDATA)
      send_next_reg <= !pins_reg.sda; // Host ack on the ninth clock
    else if (ack_end && state_reg == SEBT_RDATA && send_next_reg)
      tx_reg <= mem[addr_ptr_reg];
    else if (scl_fall && state_reg == SEBT_RDATA && bit_cnt_reg != 4'h8
             && bit_cnt_reg != 4'h0)
      tx_reg <= {tx_reg[6:0], 1'b0};
  end

  // Write pending tracks whether a STOP must launch programming
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wr_pending_reg <= 1'b0;
      prog_start_reg <= 1'b0;
    end
    else
    begin
      prog_start_reg <= stop_seen && state_reg == SEBT_WDATA && wr_pending_reg
                        && !pins_reg.wp && !busy;
      if (start_seen || stop_seen)
        wr_pending_reg <= 1'b0;
      else if (buf_store)
        wr_pending_reg <= 1'b1;
    end
  end

  // Commit scan: one buffer entry per cycle, overwrite needs no erase step
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      scan_active_reg <= 1'b0;
      scan_idx_reg <= 8'h00;
      commit_row_reg <= '0;
    end
    else if (prog_start_reg)
    begin
      scan_active_reg <= 1'b1;
      scan_idx_reg <= 8'h00;
      commit_row_reg <= addr_ptr_reg[`SEBT_ADDR_W-1:`SEBT_PAGE_W];
    end
    else if (scan_active_reg)
    begin
      scan_idx_reg <= scan_idx_reg + 8'h01;
      if (scan_idx_reg == 8'hff)
        scan_active_reg <= 1'b0;
    end
  end

  // Array write port, used only by the commit scan
  always_ff @(posedge ref_clk)
  begin
    if (scan_active_reg && buf_valid[scan_idx_reg])
      mem[{commit_row_reg, scan_idx_reg}] <= page_buf[scan_idx_reg];
  end

  // Write-time interval; bus refuses addresses until it runs out
  sebt_prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_prog_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(prog_start_reg),
    .busy(tmr_busy)
  );

  // Standby: no command in flight and no programming pending
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      standby_reg <= 1'b1;
    else
      standby_reg <= (state_reg == SEBT_IDLE || state_reg == SEBT_WAIT)
                     && !busy && !prog_start_reg;
  end

  // Open drain: the data level is always low, only the enable moves
  assign sda_out = 1'b0;
  assign sda_oe = sda_drive_reg;
  assign standby = standby_reg;
  assign prog_busy = busy;

endmodule // sebt_top

// ---- hw/sebt_defs.svh ----
// Constants of the two-wire EEPROM bus target: field positions, sizes, timing.
// Included by the package users; holds definitions only.
`ifndef SEBT_DEFS_SVH
`define SEBT_DEFS_SVH

// Memory geometry
`define SEBT_ADDR_W 17
`define SEBT_PAGE_W 8
`define SEBT_PAGE_BYTES 256
`define SEBT_MEM_BYTES 131072

// Device address word layout, bit 7 sent first
`define SEBT_DEV_TYPE 4'ha
`define SEBT_SEL_HI_BIT 3
`define SEBT_SEL_LO_BIT 2
`define SEBT_PAGE_BIT 1
`define SEBT_RW_BIT 0

// Self-timed programming
`define SEBT_CLK_MHZ 25
`define SEBT_PROG_TIME_US 5000
`define SEBT_PROG_CYCLES (`SEBT_PROG_TIME_US * `SEBT_CLK_MHZ)
`define SEBT_TMR_W 20

`endif

// ---- hw/sebt_pkg.sv ----
// Types shared by the EEPROM bus target files.
// Assumes nothing beyond a SystemVerilog compiler.
package sebt_pkg;

  // Bus front end state, one-hot
  typedef enum logic [6:0] {
    SEBT_IDLE  = 7'h01,
    SEBT_DEV   = 7'h02,
    SEBT_ADH   = 7'h04,
    SEBT_ADL   = 7'h08,
    SEBT_WDATA = 7'h10,
    SEBT_RDATA = 7'h20,
    SEBT_WAIT  = 7'h40
  } sebt_state_t;

  // Synchronised pin levels travelling together
  typedef struct packed {
    logic wp;
    logic sel_hi;
    logic sel_lo;
    logic scl;
    logic sda;
  } sebt_pins_t;

endpackage

// ---- hw/sebt_prog_timer.sv ----
// Self-timed programming interval counter.
// Assumes a single ref_clk domain and a one-cycle start pulse.
`timescale 1ns/1ps
`include "sebt_defs.svh"

module sebt_prog_timer
  import sebt_pkg::*;
#(
  parameter int CYCLES = `SEBT_PROG_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  output logic busy
);

  logic [`SEBT_TMR_W-1:0] cnt_reg;
  logic busy_reg;

  // Counts the write time down; a start while busy is ignored
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end
    else if (start && !busy_reg)
    begin
      cnt_reg <= CYCLES[`SEBT_TMR_W-1:0] - 20'h00001;
      busy_reg <= 1'b1;
    end
    else if (busy_reg)
    begin
      if (cnt_reg == '0)
        busy_reg <= 1'b0;
      else
        cnt_reg <= cnt_reg - 20'h00001;
    end
  end

  assign busy = busy_reg;

endmodule // sebt_prog_timer

// ---- test/sebt_top_properties.sv ----
// Port-level timing checks for the EEPROM bus target.
// Assumes binding onto sebt_top, with PROG_CYCLES handed on.
`timescale 1ns/1ps

module sebt_top_properties
  import sebt_pkg::*;
#(
  parameter int PROG_CYCLES = 300
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic chip_select_strap_low,
  input wire logic chip_select_strap_high,
  input wire logic write_protect,
  input wire logic standby,
  input wire logic prog_busy
);
  logic [19:0] busy_cnt_reg;

  // Length of the current busy period; a counter, since it runs past any delay
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !prog_busy)
      busy_cnt_reg <= 20'h0;
    else
      busy_cnt_reg <= busy_cnt_reg + 20'h1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Bus conditions as seen on the raw pins
  sequence s_start;
    scl_in && sda_in ##1 scl_in && !sda_in;
  endsequence
  sequence s_stop;
    scl_in && !sda_in ##1 scl_in && sda_in;
  endsequence

  a_out_zero: assert property (sda_out == 1'b0)
    else $error("sda_out not zero");
  a_busy_quiet: assert property (prog_busy |-> !sda_oe && !standby)
    else $error("ack or standby while busy");
  a_standby_quiet: assert property (standby |-> !sda_oe)
    else $error("SDA pulled in standby");
  a_wp_blocks: assert property ($rose(prog_busy) |-> !$past(write_protect, 6))
    else $error("programming under write protect");
  a_prog_bound: assert property (busy_cnt_reg <= PROG_CYCLES + 8)
    else $error("programming too long");
  a_prog_standby: assert property ($fell(prog_busy) |-> ##[1:3] standby)
    else $error("no standby after programming");
  a_start_wake: assert property (s_start ##0 !prog_busy |-> ##[1:8] !standby)
    else $error("START not taken");
  a_stop_end: assert property (s_stop |-> ##[1:8] (standby || prog_busy))
    else $error("STOP not taken");
  a_low_stands: assert property ($rose(sda_oe) |=> sda_oe [*6])
    else $error("SDA low too short");
endmodule // sebt_top_properties

bind sebt_top sebt_top_properties #(.PROG_CYCLES(PROG_CYCLES)) i_props (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .chip_select_strap_low(chip_select_strap_low),
  .chip_select_strap_high(chip_select_strap_high),
  .write_protect(write_protect),
  .standby(standby),
  .prog_busy(prog_busy)
);

// ---- test/sebt_host_model.sv ----
// Two-wire bus host model: drives SCL, pulls SDA low or releases it.
// Assumes the bench resolves SDA with a pull-up; SCL period 8 ref_clk.
`timescale 1ns/1ps

module sebt_host_model
(
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // Clock stands high between frames
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Also a repeated start: SDA is released while SCL is low first
  task automatic start_cond();
    wait_clk(1);
    sda_pull <= 1'b0;
    wait_clk(4);
    scl <= 1'b1;
    wait_clk(4);
    sda_pull <= 1'b1;
    wait_clk(4);
    scl <= 1'b0;
  endtask

  // Ends mid-cycle so callers read outputs after they settle
  task automatic stop_cond();
    wait_clk(1);
    sda_pull <= 1'b1;
    wait_clk(4);
    scl <= 1'b1;
    wait_clk(4);
    sda_pull <= 1'b0;
    wait_clk(4);
    @(negedge ref_clk);
  endtask

  // Nine clocks MSB first; a 1 in tx releases SDA for the target
  task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      wait_clk(1);
      sda_pull <= ~tx[i];
      wait_clk(3);
      scl <= 1'b1;
      wait_clk(4);
      rx[i] = sda;
      scl <= 1'b0;
    end
  endtask
endmodule // sebt_host_model

// ---- test/sebt_top_tb.sv ----
// Self-checking bench for the EEPROM bus target.
// Assumes the host model and a pulled-up SDA wire; short programming time.
`timescale 1ns/1ps

`define CHK(name, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("ERROR %s expected %h seen %h", name, exp, got); \
    end \
  end

module sebt_top_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel_hi = 1'b1;
  logic sel_lo = 1'b0;
  logic wp = 1'b0;
  logic scl;
  logic sda_pull;
  logic sda_out;
  logic sda_oe;
  logic standby;
  logic prog_busy;
  logic sda;
  logic [8:0] rx;
  int bad_count = 0;
  int total_checks = 0;

  // Open-drain wire with pull-up
  assign sda = (sda_oe || sda_pull) ? 1'b0 : 1'b1;

  always #20 ref_clk = ~ref_clk;

  sebt_top #(.PROG_CYCLES(300)) i_dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .chip_select_strap_low(sel_lo),
    .chip_select_strap_high(sel_hi),
    .write_protect(wp),
    .standby(standby),
    .prog_busy(prog_busy)
  );

  sebt_host_model i_host (
    .ref_clk(ref_clk),
    .sda(sda),
    .scl(scl),
    .sda_pull(sda_pull)
  );

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [7:0] dev_word(input logic pg, input logic rd);
    return {4'ha, sel_hi, sel_lo, pg, rd};
  endfunction

  task automatic send(input logic [7:0] b, input logic ack);
    i_host.byte_io({b, 1'b1}, rx);
    `CHK("ack", !ack, rx[0])
  endtask

  // Write header up to the word address, page bit on top
  task automatic set_addr(input logic [16:0] a);
    i_host.start_cond();
    send(dev_word(a[16], 1'b0), 1'b1);
    send(a[15:8], 1'b1);
    send(a[7:0], 1'b1);
  endtask

  // Dummy write, repeated start, n bytes, host NACK on the last
  task automatic read_at(input logic [16:0] a, input logic [15:0] d, input int n);
    set_addr(a);
    i_host.start_cond();
    send(dev_word(1'b0, 1'b1), 1'b1);
    for (int k = 0; k < n; k++)
    begin
      i_host.byte_io({8'hff, k == n - 1}, rx);
      `CHK("rdata", d[15 - 8 * k -: 8], rx[8:1])
    end
    i_host.stop_cond();
    `CHK("read_idle", 2'b10, {standby, prog_busy})
  endtask

  task automatic write_bytes(input logic [16:0] a, input logic [23:0] d, input int n);
    set_addr(a);
    for (int k = 0; k < n; k++)
      send(d[23 - 8 * k -: 8], 1'b1);
    i_host.stop_cond();
  endtask

  // Bounded wait for programming to end
  task automatic wait_idle();
    int n;
    n = 0;
    while (prog_busy !== 1'b0 && n < 1000)
    begin
      @(posedge ref_clk);
      n++;
    end
    repeat (2) @(posedge ref_clk);
    `CHK("prog_time", 1'b1, n < 320)
    `CHK("standby", 1'b1, standby)
    if (n == 1000)
      print_verdict();
  endtask

  task automatic t_write_poll();
    write_bytes(17'h11234, 24'h5ac300, 2);
    `CHK("prog_start", 2'b01, {standby, prog_busy})
    i_host.start_cond();
    send(dev_word(1'b1, 1'b0), 1'b0);
    i_host.stop_cond();
    wait_idle();
    read_at(17'h11234, 16'h5ac3, 2);
  endtask

  // Wrong type bits, then each strap bit wrong
  task automatic t_mismatch();
    logic [7:0] w [3];
    w = '{{4'hb, sel_hi, sel_lo, 2'b00}, {4'ha, ~sel_hi, sel_lo, 2'b00},
          {4'ha, sel_hi, ~sel_lo, 2'b00}};
    for (int k = 0; k < 3; k++)
    begin
      i_host.start_cond();
      send(w[k], 1'b0);
      i_host.stop_cond();
      `CHK("nack_idle", 1'b1, standby)
    end
  endtask

  task automatic t_protect();
    @(posedge ref_clk);
    wp <= 1'b1;
    write_bytes(17'h11234, 24'ha5a500, 2);
    `CHK("wp_busy", 1'b0, prog_busy)
    read_at(17'h11234, 16'h5ac3, 2);
    @(posedge ref_clk);
    wp <= 1'b0;
  endtask

  // Straps swapped; wrap in page, overwrite without erase
  task automatic t_page();
    sel_hi <= 1'b0;
    sel_lo <= 1'b1;
    repeat (4) @(posedge ref_clk);
    write_bytes(17'h000fe, 24'h112233, 3);
    wait_idle();
    read_at(17'h000fe, 16'h1122, 2);
    read_at(17'h00000, 16'h3300, 1);
    write_bytes(17'h11234, 24'h770000, 1);
    wait_idle();
    read_at(17'h11234, 16'h77c3, 2);
  endtask

  // Reset, then the scenarios in order
  initial
  begin
    repeat (16) @(posedge ref_clk);
    `CHK("rst_state", 3'b100, {standby, prog_busy, sda_oe})
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_write_poll();
    t_mismatch();
    t_protect();
    t_page();
    print_verdict();
  end
endmodule // sebt_top_tb
